// File: adc_timing_params.svh
// Constants for the conversion timing core
`ifndef ADC_TIMING_PARAMS_SVH
`define ADC_TIMING_PARAMS_SVH
`define CODE_MAX 24'h7fffff
`define CODE_MIN 24'h800000
`define CONV_HS_CLKS 10'h100
`define CONV_HR_CLKS 10'h200
`define FRAME_SHORT 10'h100
`define FRAME_LONG 10'h200
`define FRAME_TOL 10'h008
`define FRAME_CNT_MAX 10'h3ff
`define FRAME_LONG_RESET 1'b1
// Divider code zero stands for eight
`define MOD_DIV_FAST 3'h2
`define MOD_DIV_MID 3'h4
`define MOD_DIV_SLOW 3'h0
`define SRC_CLK_PERIOD_NS 800
`define SYS_CLK_PERIOD_NS 100
`endif

// File: adc_timing_pkg.sv
// Types for the conversion timing core
package adc_timing_pkg;
	typedef enum logic [1:0] {MODE_HS, MODE_HR, MODE_LP} op_mode_e;
	typedef enum logic [1:0] {FMT_SPI, FMT_MOD, FMT_FRAME} fmt_e;
endpackage

// File: adc_tick_if.sv
// Conversion clock events shared between core and rate divider
`timescale 1ns/1ps
interface adc_tick_if;
	logic conv_edge;
	logic [2:0] mod_div;
	logic mod_strobe;
	modport core (output conv_edge, output mod_div, input mod_strobe);
	modport div (input conv_edge, input mod_div, output mod_strobe);
endinterface

// File: adc_mod_divider.sv
// Modulator sample strobe divider
`timescale 1ns/1ps
`include "adc_timing_params.svh"
module adc_mod_divider (
	input wire logic clk,
	input wire logic reset_n,
	adc_tick_if.div tick
);
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic strobe;
	logic next_strobe;
	always_comb begin
		next_cnt = cnt;
		next_strobe = 1'b0;
		if (tick.conv_edge) begin
			// Code zero minus one wraps to seven, so it divides by eight
			if (cnt == tick.mod_div - 3'h1) begin
				next_cnt = 3'h0;
				next_strobe = 1'b1;
			end else begin
				next_cnt = cnt + 3'h1;
			end
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 3'h0;
			strobe <= 1'b0;
		end else begin
			cnt <= next_cnt;
			strobe <= next_strobe;
		end
	end
	assign tick.mod_strobe = strobe;
endmodule // adc_mod_divider

// File: adc_conversion_timing.sv
// Conversion timing core: rates, frame detection, result coding
// Operation
// - A full-scale positive input gives code 7fffff.
// - A full-scale negative input gives code 800000.
// - High-speed conversions last 256 conversion clocks.
// - High-resolution and low-power in SPI format last 512 conversion clocks.
// - In frame-sync format the frame length of 256 or 512 is detected automatically.
// - The modulator rate is clock/2, /4 or /8 by mode, format and frame length.
// - In high-resolution and low-power, a 256 frame keeps the data rate at half the clock of a 512 frame; high-speed ignores the frame length.
// - Results come at a fixed fraction of the conversion clock.
// - A bypass presents the raw modulator bit instead of filtered results.
// - Configuration comes only from pin levels; there are no registers.
// - Three modes are offered: high-speed, high-resolution, low-power.
// - Results leave over an SPI or frame-sync link.
`timescale 1ns/1ps
`include "adc_timing_params.svh"
module adc_conversion_timing #(
	parameter int DATA_W = 24
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic conv_clk,
	input wire logic frame_boundary_input,
	input wire adc_timing_pkg::op_mode_e mode_sel,
	input wire adc_timing_pkg::fmt_e format_sel,
	input wire logic signed [DATA_W:0] sample_in,
	input wire logic signed [DATA_W:0] ref_in,
	input wire logic mod_bit_in,
	output logic [DATA_W-1:0] result,
	output logic result_valid,
	output logic mod_bit_out,
	output logic mod_sample,
	output logic frame_is_long,
	output logic bypass_active
);
	// Pin configuration only, no registers
	logic [1:0] pin_raw;
	logic [1:0] pin_level;
	logic cclk_level;
	logic frame_boundary_input_level;
	logic [9:0] conv_cnt;
	logic [9:0] next_conv_cnt;
	logic [9:0] frame_cnt;
	logic [9:0] next_frame_cnt;
	logic long_frame;
	logic next_long_frame;
	logic [DATA_W-1:0] next_result;
	logic next_valid;
	logic next_mod_bit;
	logic conv_rise;
	logic frame_boundary_input_rise;
	logic [9:0] conv_len;
	logic next_bypass;
	adc_tick_if tick ();

	function automatic logic near_len(input logic [9:0] n, input logic [9:0] target);
		near_len = (n + `FRAME_TOL >= target) && (n <= target + `FRAME_TOL);
	endfunction

	// A short frame only matters in frame-sync format; SPI always runs the long ratios
	function automatic logic short_frame(input adc_timing_pkg::fmt_e fmt, input logic is_long);
		short_frame = (fmt == adc_timing_pkg::FMT_FRAME) && !is_long;
	endfunction

	// Three-stage sampling; a change counts when stages two and three agree
	// One copy per pin, so both pins see the same delay and their edges stay aligned
	assign pin_raw = {frame_boundary_input, conv_clk};
	for (genvar p = 0; p < 2; p++) begin : g_pin
		logic [2:0] stages;
		logic [2:0] next_stages;
		logic level;
		logic next_level;
		always_comb begin
			next_stages = {stages[1:0], pin_raw[p]};
			next_level = level;
			if (stages[1] == stages[2])
				next_level = stages[2];
		end
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				stages <= 3'h0;
				level <= 1'b0;
			end else begin
				stages <= next_stages;
				level <= next_level;
			end
		end
		assign pin_level[p] = level;
	end
	assign cclk_level = pin_level[0];
	assign frame_boundary_input_level = pin_level[1];
	logic cclk_prev;
	logic frame_boundary_input_prev;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cclk_prev <= 1'b0;
			frame_boundary_input_prev <= 1'b0;
		end else begin
			cclk_prev <= cclk_level;
			frame_boundary_input_prev <= frame_boundary_input_level;
		end
	end
	// Conversion clock is supplied from outside; nothing runs without it
	assign conv_rise = cclk_level & ~cclk_prev;
	assign frame_boundary_input_rise = frame_boundary_input_level & ~frame_boundary_input_prev;

	// Conversion length by mode, format and detected frame
	always_comb begin
		conv_len = `CONV_HR_CLKS;
		if (mode_sel == adc_timing_pkg::MODE_HS)
			conv_len = `CONV_HS_CLKS;
		else if (short_frame(format_sel, long_frame))
			conv_len = `CONV_HS_CLKS;
	end

	// Modulator divider: HS /4; HR /4 or /2 with short frame; LP /8 or /4
	always_comb begin
		tick.mod_div = `MOD_DIV_MID;
		unique case (mode_sel)
			adc_timing_pkg::MODE_HS: tick.mod_div = `MOD_DIV_MID;
			adc_timing_pkg::MODE_HR: tick.mod_div =
				short_frame(format_sel, long_frame) ? `MOD_DIV_FAST : `MOD_DIV_MID;
			adc_timing_pkg::MODE_LP: tick.mod_div =
				short_frame(format_sel, long_frame) ? `MOD_DIV_MID : `MOD_DIV_SLOW;
			default: tick.mod_div = `MOD_DIV_MID;
		endcase
	end
	assign tick.conv_edge = conv_rise;
	adc_mod_divider u_div (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick)
	);

	// Frame length detection; ratios other than 256 or 512 are the host's fault
	always_comb begin
		next_frame_cnt = frame_cnt;
		next_long_frame = long_frame;
		if (frame_boundary_input_rise) begin
			next_frame_cnt = 10'h0;
			if (near_len(frame_cnt, `FRAME_LONG))
				next_long_frame = 1'b1;
			else if (near_len(frame_cnt, `FRAME_SHORT))
				next_long_frame = 1'b0;
		end else if (conv_rise && frame_cnt != `FRAME_CNT_MAX) begin
			next_frame_cnt = frame_cnt + 10'h1;
		end
	end

	// Detection starts at the long ratio until a frame has been measured
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_cnt <= 10'h0;
			long_frame <= `FRAME_LONG_RESET;
		end else begin
			frame_cnt <= next_frame_cnt;
			long_frame <= next_long_frame;
		end
	end

	// Saturating two's complement coding, linear in between
	function automatic logic [DATA_W-1:0] code_of(input logic signed [DATA_W:0] v,
		input logic signed [DATA_W:0] r);
		if (v >= r)
			code_of = `CODE_MAX;
		else if (v <= -r)
			code_of = `CODE_MIN;
		else
			code_of = v[DATA_W-1:0];
	endfunction

	// One result per conversion period outside bypass format, fixed ratio to the clock
	always_comb begin
		next_conv_cnt = conv_cnt;
		next_result = result;
		next_valid = 1'b0;
		if (conv_rise) begin
			if (conv_cnt + 10'h1 >= conv_len) begin
				next_conv_cnt = 10'h0;
				if (format_sel != adc_timing_pkg::FMT_MOD) begin
					next_result = code_of(sample_in, ref_in);
					next_valid = 1'b1;
				end
			end else begin
				next_conv_cnt = conv_cnt + 10'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_cnt <= 10'h0;
			result <= '0;
			result_valid <= 1'b0;
		end else begin
			conv_cnt <= next_conv_cnt;
			result <= next_result;
			result_valid <= next_valid;
		end
	end

	// Bypass passes the raw bit on each modulator strobe
	// The flag is registered with the bit so both change on the same edge
	always_comb begin
		next_bypass = (format_sel == adc_timing_pkg::FMT_MOD);
		next_mod_bit = mod_bit_out;
		if (next_bypass && tick.mod_strobe)
			next_mod_bit = mod_bit_in;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mod_bit_out <= 1'b0;
			bypass_active <= 1'b0;
		end else begin
			mod_bit_out <= next_mod_bit;
			bypass_active <= next_bypass;
		end
	end

	assign mod_sample = tick.mod_strobe;
	assign frame_is_long = long_frame;
endmodule // adc_conversion_timing

// File: adc_host_model.sv
// Far side model: free running conversion clock and frame marks
`timescale 1ns/1ps
module adc_host_model (
	input wire logic [9:0] frame_len,
	output logic conv_clk,
	output logic frame_boundary_input
);
	int n = 0;
	initial begin
		conv_clk = 1'b0;
		frame_boundary_input = 1'b0;
		#37;
		forever begin
			#400 conv_clk = ~conv_clk;
			if (conv_clk) begin
				n = (n + 1) % frame_len;
				frame_boundary_input = (n < 4);
			end
		end
	end
endmodule // adc_host_model

// File: adc_conversion_timing_assertions.sv
// Assertions on the conversion timing core ports
`timescale 1ns/1ps
`include "adc_timing_params.svh"
module adc_conversion_timing_assertions #(
	parameter int DATA_W = 24
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire adc_timing_pkg::fmt_e format_sel,
	input wire logic signed [DATA_W:0] sample_in,
	input wire logic signed [DATA_W:0] ref_in,
	input wire logic [DATA_W-1:0] result,
	input wire logic result_valid,
	input wire logic mod_sample,
	input wire logic mod_bit_in,
	input wire logic mod_bit_out,
	input wire logic bypass_active
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Input held a few cycles so the capture edge is unambiguous
	chk_code_top: assert property (result_valid && $past(sample_in, 3) == sample_in && sample_in >= ref_in
		|-> result == `CODE_MAX) else $error("top code wrong");
	chk_code_bottom: assert property (result_valid && $past(sample_in, 3) == sample_in && sample_in <= -ref_in
		|-> result == `CODE_MIN) else $error("bottom code wrong");
	chk_code_linear: assert property (result_valid && $past(sample_in, 3) == sample_in && sample_in > -ref_in
		&& sample_in < ref_in |-> result == sample_in[DATA_W-1:0]) else $error("mid code wrong");
	chk_bypass_follow: assert property (format_sel == adc_timing_pkg::FMT_MOD && mod_sample
		|=> mod_bit_out == $past(mod_bit_in)) else $error("bypass bit not passed");
	chk_bypass_quiet: assert property ($past(bypass_active, 2) && bypass_active |-> !result_valid)
		else $error("result in bypass");
	chk_valid_pulse: assert property (result_valid |=> !result_valid [*8]) else $error("valid too long");
	chk_mod_pulse: assert property (mod_sample |=> !mod_sample [*8]) else $error("mod strobe too close");
	chk_result_hold: assert property (!result_valid |-> $stable(result)) else $error("result moved");
endmodule // adc_conversion_timing_assertions

// File: adc_conversion_timing_tb.sv
// Self-checking bench for the conversion timing core
`timescale 1ns/1ps
module adc_conversion_timing_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic conv_clk, frame_boundary_input, mod_bit_in = 1'b0;
	logic [9:0] flen = 10'h200;
	adc_timing_pkg::op_mode_e mode_sel = adc_timing_pkg::MODE_HS;
	adc_timing_pkg::fmt_e format_sel = adc_timing_pkg::FMT_SPI;
	logic signed [24:0] sample_in = 25'h0000000;
	logic signed [24:0] ref_in = 25'h0400000;
	logic [24:0] sv [3] = '{25'h0500000, 25'h1c00000, 25'h1fffff0};
	logic [23:0] ev [3] = '{24'h7fffff, 24'h800000, 24'hfffff0};
	logic [23:0] result;
	logic result_valid, mod_bit_out, mod_sample, frame_is_long, bypass_active;
	int errors = 0;
	int total_checks = 0;
	initial begin
		forever #50 clk = ~clk;
	end
	adc_host_model u_host (.frame_len(flen), .conv_clk(conv_clk), .frame_boundary_input(frame_boundary_input));
	adc_conversion_timing u_dut (.clk(clk), .reset_n(reset_n), .conv_clk(conv_clk),
		.frame_boundary_input(frame_boundary_input), .mode_sel(mode_sel), .format_sel(format_sel),
		.sample_in(sample_in), .ref_in(ref_in), .mod_bit_in(mod_bit_in), .result(result),
		.result_valid(result_valid), .mod_bit_out(mod_bit_out), .mod_sample(mod_sample),
		.frame_is_long(frame_is_long), .bypass_active(bypass_active));
	task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// Counts clocks and modulator strobes up to the next result
	task automatic next_valid(output int n, output int m);
		n = 0;
		m = 0;
		do begin
			tick();
			n++;
			if (mod_sample === 1'b1) m++;
		end while (result_valid !== 1'b1 && n < 6000);
		if (n >= 6000) begin
			errors++;
			end_sim();
		end
	endtask
	task automatic t_codes();
		int n, m;
		for (int i = 0; i < 3; i++) begin
			sample_in = sv[i];
			next_valid(n, m);
			next_valid(n, m);
			check("code", result, ev[i]);
		end
		$display("codes done");
	endtask
	// Third interval only: the first two may straddle a mode or frame change
	task automatic run_cfg(adc_timing_pkg::op_mode_e md, adc_timing_pkg::fmt_e fm, logic [9:0] fl, int len, int dv);
		int n, m;
		mode_sel = md;
		format_sel = fm;
		flen = fl;
		repeat (3) next_valid(n, m);
		check("period", 24'((n + 4) / 8), 24'(len));
		check("mod rate", 24'((m + 2) / 4), 24'(len / dv / 4));
		if (fm == adc_timing_pkg::FMT_FRAME) check("frame long", 24'(frame_is_long), 24'(fl == 10'h200));
		$display("config %0d %0d done", md, fm);
	endtask
	task automatic t_bypass();
		int v = 0;
		format_sel = adc_timing_pkg::FMT_MOD;
		for (int b = 1; b >= 0; b--) begin
			mod_bit_in = b[0];
			repeat (2300) begin
				tick();
				if (result_valid === 1'b1) v++;
			end
			check("mod bit", 24'(mod_bit_out), 24'(b));
		end
		check("bypass", {v[22:0], bypass_active}, 24'h1);
		$display("bypass done");
	endtask
	initial begin
		repeat (12) tick();
		reset_n = 1'b1;
		t_codes();
		run_cfg(adc_timing_pkg::MODE_HS, adc_timing_pkg::FMT_SPI, 10'h200, 256, 4);
		run_cfg(adc_timing_pkg::MODE_HR, adc_timing_pkg::FMT_SPI, 10'h200, 512, 4);
		run_cfg(adc_timing_pkg::MODE_LP, adc_timing_pkg::FMT_SPI, 10'h200, 512, 8);
		run_cfg(adc_timing_pkg::MODE_LP, adc_timing_pkg::FMT_FRAME, 10'h200, 512, 8);
		run_cfg(adc_timing_pkg::MODE_HR, adc_timing_pkg::FMT_FRAME, 10'h100, 256, 2);
		run_cfg(adc_timing_pkg::MODE_LP, adc_timing_pkg::FMT_FRAME, 10'h100, 256, 4);
		run_cfg(adc_timing_pkg::MODE_HS, adc_timing_pkg::FMT_FRAME, 10'h100, 256, 4);
		t_bypass();
		end_sim();
	end
endmodule // adc_conversion_timing_tb
bind adc_conversion_timing adc_conversion_timing_assertions #(.DATA_W(DATA_W)) u_chk (.clk(clk),
	.reset_n(reset_n), .format_sel(format_sel), .sample_in(sample_in), .ref_in(ref_in), .result(result),
	.result_valid(result_valid), .mod_sample(mod_sample), .mod_bit_in(mod_bit_in), .mod_bit_out(mod_bit_out),
	.bypass_active(bypass_active));
